// ---- verilog/dfs_pkg.sv ----
// dfs_pkg: constants, types and encodings of the fault status capture block
// assumes a single core clock; no timing constants are needed
package dfs_pkg;

  // privilege levels of the requesting instruction
  typedef enum logic [1:0] {
    DFS_LVL_USER = 2'h0,
    DFS_LVL_KERNEL = 2'h1,
    DFS_LVL_VIRT = 2'h2
  } dfs_level_type;

  // outcome of a system register access
  typedef enum logic [1:0] {
    DFS_RESP_DONE = 2'h0,
    DFS_RESP_UNDEF_KERNEL = 2'h1,
    DFS_RESP_UNDEF_VIRT = 2'h2,
    DFS_RESP_TRAP_VIRT = 2'h3
  } dfs_resp_type;

  // coprocessor instruction fields
  typedef struct packed {
    logic [3:0] coproc;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic write;
    logic [31:0] wdata;
    dfs_level_type level;
  } dfs_req_type;

  // trap and routing controls from the virtualisation registers
  typedef struct packed {
    logic virt_level_present;
    logic debug_access_trap;
    logic vm_write_trap;
    logic vm_read_trap;
    logic trap_primary_reg5;
    logic trap_primary_reg1;
    logic general_exception_route;
    logic access_ctrl_fault;
  } dfs_trap_type;

  // data abort report from the memory pipeline
  typedef struct packed {
    logic [5:0] status;
    logic write_not_read;
    logic cache_maint_fault;
    logic sys_instr_fault;
    logic external_abort_type;
    logic fault_address_invalid;
  } dfs_abort_type;

  // register encodings
  localparam logic [3:0] DFS_CP14 = 4'he;
  localparam logic [3:0] DFS_CP15 = 4'hf;
  localparam logic [2:0] DFS_DSCR_OPC1 = 3'h0;
  localparam logic [3:0] DFS_DSCR_CRN = 4'h0;
  localparam logic [3:0] DFS_DSCR_CRM = 4'h2;
  localparam logic [2:0] DFS_DSCR_OPC2 = 3'h2;
  localparam logic [2:0] DFS_DATA_FAULT_STATUS_OPC1 = 3'h0;
  localparam logic [3:0] DFS_DATA_FAULT_STATUS_CRN = 4'h5;
  localparam logic [3:0] DFS_DATA_FAULT_STATUS_CRM = 4'h0;
  localparam logic [2:0] DFS_DATA_FAULT_STATUS_OPC2 = 3'h0;
  localparam logic [2:0] DFS_FTR_OPC1 = 3'h4;
  localparam logic [3:0] DFS_FTR_CRN = 4'h1;
  localparam logic [3:0] DFS_FTR_CRM = 4'h1;
  localparam logic [2:0] DFS_FTR_OPC2 = 3'h2;

  // debug entry methods
  localparam logic [3:0] DFS_MOE_BREAKPOINT = 4'h1;
  localparam logic [3:0] DFS_MOE_SW_SOFTWARE_BREAKPOINT_INSTR = 4'h3;
  localparam logic [3:0] DFS_MOE_VECTOR = 4'h5;
  localparam logic [3:0] DFS_MOE_WATCHPOINT = 4'ha;

  // fault status codes
  localparam logic [5:0] DFS_ST_TRANSLATION = 6'h04;
  localparam logic [5:0] DFS_ST_PERMISSION = 6'h0c;
  localparam logic [5:0] DFS_ST_SYNC_EXT = 6'h10;
  localparam logic [5:0] DFS_ST_SYSTEM_ERROR_INTERRUPT = 6'h11;
  localparam logic [5:0] DFS_ST_SYNC_PARITY = 6'h18;
  localparam logic [5:0] DFS_ST_SYSTEM_ERROR_INTERRUPT_PARITY = 6'h19;
  localparam logic [5:0] DFS_ST_ALIGNMENT = 6'h21;
  localparam logic [5:0] DFS_ST_DEBUG = 6'h22;
  localparam logic [5:0] DFS_ST_LOCKDOWN = 6'h34;
  localparam logic [5:0] DFS_ST_EXCLUSIVE = 6'h35;

  // field positions
  localparam int DFS_FNV_BIT = 16;
  localparam int DFS_CM_BIT = 13;
  localparam int DFS_EXT_BIT = 12;
  localparam int DFS_WNR_BIT = 11;
  localparam int DFS_LONG_DESC_BIT = 9;
  localparam int DFS_MOE_LSB = 2;
  localparam int DFS_MDBG_BIT = 15;
  localparam int DFS_UDCC_BIT = 12;
  localparam int DFS_NS_BIT = 18;

  // save/restore fields of the external debug status/control view
  localparam logic [31:0] DFS_DSCR_SR_MASK = 32'h6ee04040;
  // software-owned control bits of that view
  localparam logic [31:0] DFS_DSCR_CTL_MASK = 32'h00009000;
  // reset values (unspecified fields come up as zero)
  localparam logic [31:0] DFS_DSCR_RESET = 32'h00000000;
  localparam logic [31:0] DFS_DATA_FAULT_STATUS_RESET = 32'h00000000;
  localparam logic [31:0] DFS_FTR_RESET_VIRT = 32'h000033ff;

endpackage : dfs_pkg

// ---- verilog/dfs_fault_status.sv ----
// dfs_fault_status: debug entry method and data fault status recording,
// with coprocessor register access and the trap checks that guard it
// assumes requests are one-cycle pulses synchronous to mclk_in and that
// the trap controls are held stable by the virtualisation registers
//
// Overview of operation
// - debug entry writes method code into bits 5:2
// - entry method field reset value is unspecified
// - cp14 0/c0/c2/2 reaches debug view, no user
// - OS lock clear makes save/restore fields read-only
// - debug access trap sends kernel accesses to virt
// - each known-code data abort replaces fault status; reset unspecified
// - bit 16 marks invalid fault address, sync external
// - bit 13 marks cache maintenance sync fault
// - bit 12 external abort class, zero otherwise
// - bit 11 records write versus read
// - cp15 system instruction faults force write bit
// - translation, permission, alignment, debug status codes
// - external abort and system error status codes
// - lockdown and exclusive codes; reserved never produced
// - cp15 0/c5/c0/0 reaches fault status, no user
// - vm write trap sends kernel writes to virt
// - vm read trap sends kernel reads to virt
// - primary reg 5 trap sends kernel accesses
// - feature trap register virt only, reg1 trap
// - feature trap defined reset only into virt
// - access control faults beat feature trap traps
// - OS lock set: save/restore fields writable, live
// - general route sends kernel exceptions to virt
`timescale 1ns/1ps

module dfs_fault_status #(
  parameter bit EXT_CLASS_IMPL = 1'b0 // external abort class provided
) (
  input wire logic mclk_in, // core clock, 25 MHz
  input wire logic reset_in, // synchronous, active high
  input wire logic reset_into_virt_in, // core resets into virt level
  input wire logic req_valid_in, // register access request pulse
  input wire dfs_pkg::dfs_req_type req_in, // access encoding and data
  input wire dfs_pkg::dfs_trap_type trap_in, // trap controls
  input wire logic os_lock_flag_in, // OS lock set
  input wire logic [31:0] ext_live_in, // live external debug status
  input wire logic dbg_entry_in, // debug exception taken pulse
  input wire logic [3:0] dbg_method_in, // entry method code
  input wire logic abort_in, // data abort taken pulse
  input wire dfs_pkg::dfs_abort_type abort_info_in, // abort cause
  output logic resp_valid_out, // answer pulse
  output dfs_pkg::dfs_resp_type resp_out, // answer outcome
  output logic [31:0] rdata_out, // read data
  output logic ext_restore_out, // restore strobe to debug logic
  output logic [31:0] ext_restore_data_out, // restored field values
  output logic [31:0] data_fault_status_out, // fault status view
  output logic [31:0] feature_trap_out // feature trap register
);
  import dfs_pkg::*;

  function automatic logic is_known_status(input logic [5:0] st);
    case (st)
      DFS_ST_TRANSLATION, DFS_ST_PERMISSION, DFS_ST_SYNC_EXT,
      DFS_ST_SYSTEM_ERROR_INTERRUPT, DFS_ST_SYNC_PARITY, DFS_ST_SYSTEM_ERROR_INTERRUPT_PARITY,
      DFS_ST_ALIGNMENT, DFS_ST_DEBUG, DFS_ST_LOCKDOWN,
      DFS_ST_EXCLUSIVE: is_known_status = 1'b1;
      default: is_known_status = 1'b0;
    endcase
  endfunction : is_known_status

  function automatic logic is_external(input logic [5:0] st);
    is_external = (st == DFS_ST_SYNC_EXT) || (st == DFS_ST_SYSTEM_ERROR_INTERRUPT) ||
                  (st == DFS_ST_SYNC_PARITY) ||
                  (st == DFS_ST_SYSTEM_ERROR_INTERRUPT_PARITY);
  endfunction : is_external

  function automatic logic is_async(input logic [5:0] st);
    is_async = (st == DFS_ST_SYSTEM_ERROR_INTERRUPT) || (st == DFS_ST_SYSTEM_ERROR_INTERRUPT_PARITY);
  endfunction : is_async

  function automatic logic enc_match(input dfs_req_type r,
                                     input logic [3:0] cp,
                                     input logic [2:0] o1,
                                     input logic [3:0] n,
                                     input logic [3:0] m,
                                     input logic [2:0] o2);
    enc_match = (r.coproc == cp) && (r.opc1 == o1) && (r.crn == n) &&
                (r.crm == m) && (r.opc2 == o2);
  endfunction : enc_match

  logic [31:0] dscr_ctl_r;
  logic [31:0] dscr_ctl_nxt;
  logic [3:0] entry_method_r;
  logic [3:0] entry_method_nxt;
  logic [31:0] fault_r;
  logic [31:0] fault_nxt;
  logic [31:0] ftr_r;
  logic [31:0] ftr_nxt;
  logic resp_valid_r;
  dfs_resp_type resp_r;
  dfs_resp_type resp_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic restore_r;
  logic [31:0] restore_data_r;

  // register selection
  wire logic sel_dscr = enc_match(req_in, DFS_CP14, DFS_DSCR_OPC1,
                        DFS_DSCR_CRN, DFS_DSCR_CRM, DFS_DSCR_OPC2);
  wire logic sel_data_fault_status = enc_match(req_in, DFS_CP15, DFS_DATA_FAULT_STATUS_OPC1,
                        DFS_DATA_FAULT_STATUS_CRN, DFS_DATA_FAULT_STATUS_CRM, DFS_DATA_FAULT_STATUS_OPC2);
  wire logic sel_ftr = enc_match(req_in, DFS_CP15, DFS_FTR_OPC1,
                       DFS_FTR_CRN, DFS_FTR_CRM, DFS_FTR_OPC2);
  wire logic sel_any = sel_dscr || sel_data_fault_status || sel_ftr;

  wire logic lvl_user = (req_in.level == DFS_LVL_USER);
  wire logic lvl_kernel = (req_in.level == DFS_LVL_KERNEL);
  wire logic lvl_virt = (req_in.level == DFS_LVL_VIRT);
  wire logic hyp = trap_in.virt_level_present;

  // kernel-level traps to virt, per register
  wire logic trap_dscr = hyp && trap_in.debug_access_trap;
  wire logic trap_data_fault_status_wr = hyp && trap_in.vm_write_trap &&
                            req_in.write;
  wire logic trap_data_fault_status_rd = hyp && trap_in.vm_read_trap &&
                            !req_in.write;
  wire logic trap_data_fault_status_r5 = hyp && trap_in.trap_primary_reg5;
  wire logic trap_data_fault_status = trap_data_fault_status_wr || trap_data_fault_status_rd || trap_data_fault_status_r5;
  wire logic trap_ftr = hyp && trap_in.trap_primary_reg1;

  wire logic kernel_trap = lvl_kernel && ((sel_dscr && trap_dscr) ||
                           (sel_data_fault_status && trap_data_fault_status) || (sel_ftr && trap_ftr));
  // undefined at this level: user level, unmapped, feature trap below virt
  wire logic ftr_undef = sel_ftr && lvl_kernel && !trap_ftr;
  wire logic undef_acc = !sel_any || lvl_user || ftr_undef ||
                         (sel_ftr && trap_in.access_ctrl_fault);
  // kernel-bound exceptions go to virt under general routing
  wire logic route_virt = trap_in.general_exception_route ||
                          lvl_virt;
  wire logic acc_ok = req_valid_in && !undef_acc && !kernel_trap;
  wire logic acc_wr = acc_ok && req_in.write;

  // external debug status/control read view
  wire logic [31:0] dscr_view = (ext_live_in & DFS_DSCR_SR_MASK) |
    (dscr_ctl_r & DFS_DSCR_CTL_MASK) |
    (32'h1 << DFS_NS_BIT) |
    {26'h0, entry_method_r, 2'h0};
  // save/restore fields accept writes only while locked
  wire logic sr_write = acc_wr && sel_dscr && os_lock_flag_in;

  // captured abort image, all fields formed together
  wire logic [5:0] ab_st = abort_info_in.status;
  wire logic ab_ok = abort_in && is_known_status(ab_st);
  wire logic ab_sync_ext = (ab_st == DFS_ST_SYNC_EXT) ||
                           (ab_st == DFS_ST_SYNC_PARITY);
  wire logic [31:0] ab_image =
    (32'(ab_sync_ext && abort_info_in.fault_address_invalid)
      << DFS_FNV_BIT) |
    (32'(!is_async(ab_st) && abort_info_in.cache_maint_fault)
      << DFS_CM_BIT) |
    (32'(EXT_CLASS_IMPL && is_external(ab_st) &&
      abort_info_in.external_abort_type) << DFS_EXT_BIT) |
    (32'(abort_info_in.write_not_read ||
      abort_info_in.sys_instr_fault) << DFS_WNR_BIT) |
    (32'h1 << DFS_LONG_DESC_BIT) |
    {26'h0, ab_st};
  // writable bits of the fault status register
  wire logic [31:0] data_fault_status_wmask = 32'h0001383f;

  // next-state selection; hardware events win over software writes
  assign entry_method_nxt = dbg_entry_in ? dbg_method_in :
    (acc_wr && sel_dscr) ? req_in.wdata[DFS_MOE_LSB +: 4] :
    entry_method_r;
  assign dscr_ctl_nxt = (acc_wr && sel_dscr) ?
    (req_in.wdata & DFS_DSCR_CTL_MASK) : dscr_ctl_r;
  assign fault_nxt = ab_ok ? ab_image :
    (acc_wr && sel_data_fault_status) ?
      ((req_in.wdata & data_fault_status_wmask) | (32'h1 << DFS_LONG_DESC_BIT)) :
    fault_r;
  assign ftr_nxt = (acc_wr && sel_ftr) ? req_in.wdata : ftr_r;

  assign resp_nxt = !req_valid_in ? DFS_RESP_DONE :
    undef_acc ? (route_virt ? DFS_RESP_UNDEF_VIRT :
                 DFS_RESP_UNDEF_KERNEL) :
    kernel_trap ? DFS_RESP_TRAP_VIRT : DFS_RESP_DONE;
  assign rdata_nxt = !(acc_ok && !req_in.write) ? 32'h0 :
    sel_dscr ? dscr_view :
    sel_data_fault_status ? fault_r : ftr_r;

  // debug and fault state; entry method and fault reset unspecified
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      entry_method_r <= 4'h0;
      dscr_ctl_r <= DFS_DSCR_RESET;
      fault_r <= DFS_DATA_FAULT_STATUS_RESET;
    end else begin
      entry_method_r <= entry_method_nxt;
      dscr_ctl_r <= dscr_ctl_nxt;
      fault_r <= fault_nxt;
    end
  end

  // reset strap caught on the first edge after release
  logic strap_virt_r;
  logic reset_into_virt_done_r;

  // feature trap register: defined reset only when entering virt
  // strap_virt_r is high for the one cycle after the first edge
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ftr_r <= 32'h0;
    end else if (strap_virt_r) begin
      ftr_r <= DFS_FTR_RESET_VIRT;
    end else begin
      ftr_r <= ftr_nxt;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      strap_virt_r <= 1'b0;
      reset_into_virt_done_r <= 1'b0;
    end else begin
      strap_virt_r <= reset_into_virt_in && !reset_into_virt_done_r;
      reset_into_virt_done_r <= 1'b1;
    end
  end

  // access answer and restore strobe
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      resp_valid_r <= 1'b0;
      resp_r <= DFS_RESP_DONE;
      rdata_r <= 32'h0;
      restore_r <= 1'b0;
      restore_data_r <= 32'h0;
    end else begin
      resp_valid_r <= req_valid_in;
      resp_r <= resp_nxt;
      rdata_r <= rdata_nxt;
      restore_r <= sr_write;
      restore_data_r <= sr_write ? (req_in.wdata & DFS_DSCR_SR_MASK) :
                        restore_data_r;
    end
  end

  assign resp_valid_out = resp_valid_r;
  assign resp_out = resp_r;
  assign rdata_out = rdata_r;
  assign ext_restore_out = restore_r;
  assign ext_restore_data_out = restore_data_r;
  assign data_fault_status_out = fault_r;
  assign feature_trap_out = ftr_r;

endmodule : dfs_fault_status

// ---- dv/dfs_fault_status_monitor.sv ----
// dfs_fault_status_monitor: port-level checks of the fault status block
// assumes bind onto dfs_fault_status, one clock, synchronous reset
`timescale 1ns/1ps

module dfs_fault_status_monitor #(
  parameter bit EXT_CLASS_IMPL = 1'b0 // class of external aborts
) (
  input wire logic mclk_in, // clock
  input wire logic reset_in, // reset
  input wire logic req_valid_in, // request
  input wire dfs_pkg::dfs_req_type req_in, // access
  input wire dfs_pkg::dfs_trap_type trap_in, // traps
  input wire logic os_lock_flag_in, // lock
  input wire logic abort_in, // abort
  input wire dfs_pkg::dfs_abort_type abort_info_in, // cause
  input wire logic resp_valid_out, // answer
  input wire dfs_pkg::dfs_resp_type resp_out, // outcome
  input wire logic [31:0] rdata_out, // read data
  input wire logic ext_restore_out, // restore strobe
  input wire logic [31:0] data_fault_status_out // fault status
);
  import dfs_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  wire logic [17:0] enc = {req_in.coproc, req_in.opc1, req_in.crn,
    req_in.crm, req_in.opc2};
  wire logic dscr = enc == {DFS_CP14, DFS_DSCR_OPC1, DFS_DSCR_CRN,
    DFS_DSCR_CRM, DFS_DSCR_OPC2};
  wire logic data_fault_status = enc == {DFS_CP15, DFS_DATA_FAULT_STATUS_OPC1, DFS_DATA_FAULT_STATUS_CRN,
    DFS_DATA_FAULT_STATUS_CRM, DFS_DATA_FAULT_STATUS_OPC2};
  wire logic ftr = enc == {DFS_CP15, DFS_FTR_OPC1, DFS_FTR_CRN,
    DFS_FTR_CRM, DFS_FTR_OPC2};
  // kernel request with a virt level and no general routing
  wire logic kt = req_valid_in && req_in.level == DFS_LVL_KERNEL &&
    trap_in.virt_level_present && !trap_in.general_exception_route;
  wire logic dw = req_valid_in && dscr && req_in.write;
  wire logic [5:0] st = abort_info_in.status;
  wire logic legal = st inside {DFS_ST_TRANSLATION, DFS_ST_PERMISSION,
    DFS_ST_SYNC_EXT, DFS_ST_SYSTEM_ERROR_INTERRUPT, DFS_ST_SYNC_PARITY, DFS_ST_ALIGNMENT,
    DFS_ST_SYSTEM_ERROR_INTERRUPT_PARITY, DFS_ST_DEBUG, DFS_ST_LOCKDOWN, DFS_ST_EXCLUSIVE};
  wire logic cap = abort_in && legal;

  AST_ANSWER: assert property (resp_valid_out == $past(req_valid_in))
    else $error("answer not one cycle after request");
  AST_USER: assert property (req_valid_in && req_in.level == DFS_LVL_USER
    |=> resp_out != DFS_RESP_DONE) else $error("user access completed");
  AST_TDA: assert property (kt && dscr && trap_in.debug_access_trap
    |=> resp_out == DFS_RESP_TRAP_VIRT) else $error("debug trap missed");
  AST_TVM: assert property (kt && data_fault_status && req_in.write && trap_in.vm_write_trap
    |=> resp_out == DFS_RESP_TRAP_VIRT) else $error("write trap missed");
  AST_VM_READ_TRAP: assert property (kt && data_fault_status && !req_in.write &&
    trap_in.vm_read_trap |=> resp_out == DFS_RESP_TRAP_VIRT)
    else $error("read trap missed");
  AST_T5: assert property (kt && data_fault_status && trap_in.trap_primary_reg5
    |=> resp_out == DFS_RESP_TRAP_VIRT) else $error("reg5 trap missed");
  AST_T1: assert property (kt && ftr && trap_in.trap_primary_reg1 &&
    !trap_in.access_ctrl_fault |=> resp_out == DFS_RESP_TRAP_VIRT)
    else $error("reg1 trap missed");
  AST_ACF: assert property (req_valid_in && ftr && trap_in.access_ctrl_fault
    |=> resp_out inside {DFS_RESP_UNDEF_KERNEL, DFS_RESP_UNDEF_VIRT})
    else $error("access control fault not first");
  AST_RDZ: assert property (resp_valid_out && resp_out != DFS_RESP_DONE
    |-> rdata_out == 32'h0) else $error("refused access returned data");
  AST_CAP: assert property (cap |=> data_fault_status_out[5:0] == $past(st)
    && data_fault_status_out[DFS_LONG_DESC_BIT]) else $error("no capture");
  AST_FNV: assert property (cap && st != DFS_ST_SYNC_EXT
    |=> !data_fault_status_out[DFS_FNV_BIT]) else $error("address flag set");
  AST_WNR: assert property (cap |=> data_fault_status_out[DFS_WNR_BIT] ==
    ($past(abort_info_in.write_not_read) | $past(abort_info_in.sys_instr_fault)))
    else $error("direction bit wrong");
  AST_EXT: assert property (cap && !EXT_CLASS_IMPL
    |=> !data_fault_status_out[DFS_EXT_BIT]) else $error("class bit set");
  AST_RSV: assert property (abort_in && !legal && !req_valid_in
    |=> $stable(data_fault_status_out)) else $error("reserved code taken");
  AST_LOCK: assert property (dw && !os_lock_flag_in |=> !ext_restore_out)
    else $error("restore while unlocked");
  AST_RESTORE: assert property (dw && os_lock_flag_in &&
    req_in.level == DFS_LVL_VIRT |=> ext_restore_out) else $error("no restore");

  cover property (kt && data_fault_status && trap_in.trap_primary_reg5);
  cover property (cap ##1 resp_valid_out);
  cover property (ext_restore_out);
endmodule : dfs_fault_status_monitor

// ---- dv/tb_data_fault_status_capture.sv ----
// tb_data_fault_status_capture: table and directed checks of the block
// assumes dfs_pkg, dfs_fault_status and its monitor are compiled first
`timescale 1ns/1ps

bind dfs_fault_status dfs_fault_status_monitor #(
  .EXT_CLASS_IMPL(EXT_CLASS_IMPL)
) mon (.mclk_in, .reset_in, .req_valid_in, .req_in, .trap_in,
  .os_lock_flag_in, .abort_in, .abort_info_in, .resp_valid_out, .resp_out,
  .rdata_out, .ext_restore_out, .data_fault_status_out);

module tb_data_fault_status_capture;
  import dfs_pkg::*;
  logic mclk_in, reset_in, reset_into_virt_in, req_valid_in;
  logic os_lock_flag_in, dbg_entry_in, abort_in, rv, er;
  logic resp_valid_out, ext_restore_out;
  logic [3:0] dbg_method_in;
  logic [31:0] ext_live_in, rdata_out, ext_restore_data_out, rd;
  logic [31:0] data_fault_status_out, feature_trap_out;
  logic [14:0] r;
  dfs_req_type req_in;
  dfs_trap_type trap_in;
  dfs_abort_type abort_info_in;
  dfs_resp_type resp_out, rs;
  int num_errors = 0;
  int compares = 0;
  logic [3:0] debug_entry_method [4] = '{4'h1, 4'h3, 4'h5, 4'ha};
  // sel, level, write, trap controls, expected outcome
  logic [14:0] acc_rows [21] = '{
    {2'h0, 2'h0, 1'h0, 8'h00, 2'h1}, {2'h0, 2'h1, 1'h0, 8'h00, 2'h0},
    {2'h0, 2'h1, 1'h0, 8'hc0, 2'h3}, {2'h0, 2'h2, 1'h0, 8'hc0, 2'h0},
    {2'h0, 2'h1, 1'h0, 8'h40, 2'h0}, {2'h1, 2'h0, 1'h1, 8'h00, 2'h1},
    {2'h1, 2'h1, 1'h1, 8'ha0, 2'h3}, {2'h1, 2'h1, 1'h0, 8'ha0, 2'h0},
    {2'h1, 2'h1, 1'h0, 8'h90, 2'h3}, {2'h1, 2'h1, 1'h1, 8'h90, 2'h0},
    {2'h1, 2'h1, 1'h0, 8'h88, 2'h3}, {2'h1, 2'h1, 1'h1, 8'h88, 2'h3},
    {2'h1, 2'h2, 1'h1, 8'hb8, 2'h0}, {2'h2, 2'h1, 1'h0, 8'h00, 2'h1},
    {2'h2, 2'h1, 1'h0, 8'h84, 2'h3}, {2'h2, 2'h1, 1'h0, 8'h85, 2'h1},
    {2'h2, 2'h2, 1'h0, 8'h00, 2'h0}, {2'h3, 2'h1, 1'h0, 8'h00, 2'h1},
    {2'h3, 2'h2, 1'h0, 8'h00, 2'h2}, {2'h1, 2'h0, 1'h0, 8'h02, 2'h2},
    {2'h2, 2'h0, 1'h0, 8'h84, 2'h1}};
  // status, write/maint/sysinstr/ext/fnv flags, expected fault status
  logic [42:0] ab_rows [11] = '{
    {6'h10, 5'h01, 32'h00010210}, {6'h04, 5'h11, 32'h00000a04},
    {6'h0c, 5'h08, 32'h0000220c}, {6'h21, 5'h04, 32'h00000a21},
    {6'h22, 5'h02, 32'h00000222}, {6'h11, 5'h00, 32'h00000211},
    {6'h18, 5'h10, 32'h00000a18}, {6'h19, 5'h00, 32'h00000219},
    {6'h34, 5'h00, 32'h00000234}, {6'h35, 5'h10, 32'h00000a35},
    {6'h10, 5'h0a, 32'h00002210}};

  dfs_fault_status #(.EXT_CLASS_IMPL(1'b0)) dut (.mclk_in(mclk_in),
    .reset_in(reset_in), .reset_into_virt_in(reset_into_virt_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .trap_in(trap_in),
    .os_lock_flag_in(os_lock_flag_in), .ext_live_in(ext_live_in),
    .dbg_entry_in(dbg_entry_in), .dbg_method_in(dbg_method_in),
    .abort_in(abort_in), .abort_info_in(abort_info_in),
    .resp_valid_out(resp_valid_out), .resp_out(resp_out),
    .rdata_out(rdata_out), .ext_restore_out(ext_restore_out),
    .ext_restore_data_out(ext_restore_data_out),
    .data_fault_status_out(data_fault_status_out),
    .feature_trap_out(feature_trap_out));

  task automatic complete_run;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares = compares + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [17:0] enc(input logic [1:0] sel);
    case (sel)
      2'h0: enc = {DFS_CP14, DFS_DSCR_OPC1, DFS_DSCR_CRN, DFS_DSCR_CRM,
        DFS_DSCR_OPC2};
      2'h1: enc = {DFS_CP15, DFS_DATA_FAULT_STATUS_OPC1, DFS_DATA_FAULT_STATUS_CRN, DFS_DATA_FAULT_STATUS_CRM,
        DFS_DATA_FAULT_STATUS_OPC2};
      2'h2: enc = {DFS_CP15, DFS_FTR_OPC1, DFS_FTR_CRN, DFS_FTR_CRM,
        DFS_FTR_OPC2};
      default: enc = {DFS_CP15, 3'h0, 4'h9, 4'h9, 3'h7};
    endcase
  endfunction : enc

  task automatic acc(input logic [1:0] sel, lvl, input logic wr,
      input logic [31:0] wd, input logic [7:0] tr);
    @(posedge mclk_in);
    #1;
    req_in = {enc(sel), wr, wd, lvl};
    trap_in = tr;
    req_valid_in = 1'b1;
    @(posedge mclk_in);
    #1;
    req_valid_in = 1'b0;
    rv = resp_valid_out;
    rs = resp_out;
    rd = rdata_out;
    er = ext_restore_out;
    chk("resp_valid", {31'h0, rv}, 32'h1);
  endtask : acc

  task automatic ab(input logic [10:0] info);
    @(posedge mclk_in);
    #1;
    abort_info_in = info;
    abort_in = 1'b1;
    @(posedge mclk_in);
    #1;
    abort_in = 1'b0;
  endtask : ab

  task automatic do_reset;
    reset_in = 1'b1;
    repeat (10) @(posedge mclk_in);
    #1;
    chk("rst_resp", {31'h0, resp_valid_out}, 32'h0);
    reset_in = 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask : do_reset

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  initial begin
    #400000;
    num_errors = num_errors + 1;
    complete_run();
  end

  initial begin
    {reset_into_virt_in, req_valid_in, os_lock_flag_in} = 3'h0;
    {dbg_entry_in, abort_in, dbg_method_in} = 6'h00;
    {req_in, trap_in, abort_info_in, ext_live_in} = '0;
    do_reset();
    chk("ftr_rst", feature_trap_out, 32'h0);
    foreach (acc_rows[i]) begin
      r = acc_rows[i];
      acc(r[14:13], r[12:11], r[10], 32'h0, r[9:2]);
      chk("resp", {30'h0, rs}, {30'h0, r[1:0]});
      if (r[1:0] != 2'h0) begin
        chk("rdata", rd, 32'h0);
      end
    end
    foreach (ab_rows[i]) begin
      ab(ab_rows[i][42:32]);
      chk("dfs", data_fault_status_out, ab_rows[i][31:0]);
      acc(2'h1, 2'h2, 1'b0, 32'h0, 8'h00);
      chk("dfs_rd", rd, ab_rows[i][31:0]);
    end
    ab(11'h7ff);
    chk("reserved", data_fault_status_out, 32'h00002210);
    acc(2'h1, 2'h2, 1'b1, 32'hffffffff, 8'h00);
    chk("dfs_wr", data_fault_status_out, 32'h00013a3f);
    @(posedge mclk_in);
    #1;
    req_in = {enc(2'h1), 1'b1, 32'h0000383f, 2'h2};
    req_valid_in = 1'b1;
    abort_info_in = 11'h080;
    abort_in = 1'b1;
    @(posedge mclk_in);
    #1;
    req_valid_in = 1'b0;
    abort_in = 1'b0;
    chk("evt_wins", data_fault_status_out, 32'h00000204);
    foreach (debug_entry_method[i]) begin
      @(posedge mclk_in);
      #1;
      dbg_method_in = debug_entry_method[i];
      dbg_entry_in = 1'b1;
      @(posedge mclk_in);
      #1;
      dbg_entry_in = 1'b0;
      acc(2'h0, 2'h2, 1'b0, 32'h0, 8'h00);
      chk("method", {28'h0, rd[5:2]}, {28'h0, debug_entry_method[i]});
    end
    acc(2'h0, 2'h2, 1'b1, 32'hffffffff, 8'h00);
    chk("unlocked_wr", {31'h0, er}, 32'h0);
    acc(2'h0, 2'h2, 1'b0, 32'h0, 8'h00);
    chk("ro_fields", rd & 32'h6ee04040, 32'h0);
    os_lock_flag_in = 1'b1;
    ext_live_in = 32'hffffffff;
    acc(2'h0, 2'h2, 1'b1, 32'hffffffff, 8'h00);
    chk("locked_wr", {31'h0, er}, 32'h1);
    chk("restore", ext_restore_data_out, 32'h6ee04040);
    acc(2'h0, 2'h2, 1'b0, 32'h0, 8'h00);
    chk("live", rd & 32'h6ee04040, 32'h6ee04040);
    reset_into_virt_in = 1'b1;
    do_reset();
    chk("ftr_virt", feature_trap_out, 32'h000033ff);
    complete_run();
  end
endmodule : tb_data_fault_status_capture
